// *** common/chan_div_pkg.sv ***
// package: register map, field positions and shared types of the channel divider pair
package chan_div_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [9:0] idx_div0_cycle_counts = 10'h190;
   localparam logic [9:0] idx_div0_control      = 10'h191;
   localparam logic [9:0] idx_div0_routing      = 10'h192;
   localparam logic [9:0] idx_div1_cycle_counts = 10'h193;
   localparam logic [9:0] idx_div1_control      = 10'h194;
   localparam logic [9:0] idx_div1_routing      = 10'h195;
   localparam int         div_regs_per_chan     = 3;

   // clock input selection field values
   localparam logic [1:0] sel_ext_clock  = 2'h0;
   localparam logic [1:0] sel_no_effect  = 2'h1;
   localparam logic [1:0] sel_oscillator = 2'h2;

   // control and routing register field positions
   localparam int bit_bypass      = 7;
   localparam int bit_sync_ignore = 6;
   localparam int bit_force_level = 5;
   localparam int bit_start_level = 4;
   localparam int bit_direct      = 1;
   localparam int bit_duty_off    = 0;

   // reset values
   localparam logic [7:0] reset_cycle_counts = 8'h00;
   localparam logic [7:0] reset_control      = 8'h00;
   localparam logic [7:0] reset_routing      = 8'h00;

   // settings of one divider as seen by its counter
   typedef struct packed
   {
      logic [3:0] low_cycles;
      logic [3:0] high_cycles;
      logic       bypass;
      logic       sync_ignore;
      logic       force_level;
      logic       start_level;
      logic [3:0] phase_offset;
      logic       direct_route;
      logic       duty_fix_disable;
   } div_cfg_s;

   // avalon slave request bundle
   typedef struct packed
   {
      logic [11:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avl_req_s;

endpackage

// *** core/chan_div_regfile.sv ***
// register store of the divider pair, read data registered
`timescale 1ns/1ps
module chan_div_regfile
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // write port
   input  wire logic        wr_en,
   input  wire logic [2:0]  wr_sel,
   input  wire logic [7:0]  wr_data,
   // read port
   input  wire logic [2:0]  rd_sel,
   input  wire logic        rd_hit,
   output logic      [7:0]  rd_data,
   // contents
   output logic      [47:0] contents
);

   logic [7:0] store [0:5];

   // one always_ff per register slot
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : slot
         always_ff @(posedge clk)
         begin
            if (!rst_b)
               store[g] <= (g % chan_div_pkg::div_regs_per_chan == 0) ?
                           chan_div_pkg::reset_cycle_counts :
                           ((g % chan_div_pkg::div_regs_per_chan == 1) ?
                           chan_div_pkg::reset_control : chan_div_pkg::reset_routing);
            else if (wr_en && wr_sel == 3'(g))
               store[g] <= wr_data;
         end
         assign contents[g*8 +: 8] = store[g];
      end
   endgenerate

   // read data from a register; unmapped reads give zero
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rd_data <= 8'h00;
      else if (rd_hit && rd_sel < 3'd6)
         rd_data <= store[rd_sel];
      else
         rd_data <= 8'h00;
   end

endmodule

// *** core/chan_div_counter.sv ***
// one programmable channel divider with sync, force, phase and bypass
`timescale 1ns/1ps
module chan_div_counter
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   // settings and alignment
   input  wire chan_div_pkg::div_cfg_s  cfg,
   input  wire logic                    sync_req,
   // divided output
   output logic                         div_out,
   output logic                         running
);

   typedef enum logic [2:0]
   {
      st_align = 3'b001,
      st_delay = 3'b010,
      st_count = 3'b100
   } div_state_e;

   div_state_e state;
   logic [4:0] count;
   logic       level;
   logic       take_sync;

   assign take_sync = sync_req && !cfg.sync_ignore;

   // phase machine: align, wait phase offset, then toggle
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= st_align;
         count <= 5'd0;
         level <= 1'b0;
      end
      else if (take_sync || cfg.bypass)
      begin
         state <= st_align;
         count <= 5'd0;
         level <= cfg.start_level;
      end
      else
      begin
         case (state)
            st_align:
            begin
               state <= st_delay;
               count <= {1'b0, cfg.phase_offset};
               level <= cfg.start_level;
            end
            st_delay:
            begin
               if (count == 5'd0)
               begin
                  state <= st_count;
                  count <= level ? {1'b0, cfg.high_cycles} : {1'b0, cfg.low_cycles};
               end
               else
                  count <= count - 5'd1;
            end
            st_count:
            begin
               // a zero count is treated as one cycle so the output never stalls
               if (count <= 5'd1)
               begin
                  level <= !level;
                  count <= level ? {1'b0, cfg.low_cycles}
                                 : {1'b0, cfg.high_cycles};
               end
               else
                  count <= count - 5'd1;
            end
            default:
               state <= st_align;
         endcase
      end
   end

   // force only acts with sync ignored, so a sync cannot fight it;
   // the forced level is static in both polarities, even mid-count
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         div_out <= 1'b0;
      else if (cfg.sync_ignore)
         div_out <= cfg.force_level;
      else
         div_out <= level;
   end

   assign running = (state == st_count);

endmodule

// *** core/chan_div_pair.sv ***
// top of the two channel dividers with avalon register slave and output routing
//
// Summary of operation
// - low time is upper nibble cycles
// - high time is lower nibble cycles
// - bypass passes input clock straight through
// - sync ignore bit masks alignment request
// - force bit sets static output level when sync ignore is set
// - start bit picks initial output level
// - four bit phase offset delays start
// - direct bit zero selects divider output
// - direct with select 10 routes oscillator
// - select 00 routes external; 01 unchanged
// - duty fix disable bit turns correction off
// - divider zero at 190, one at 193
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module chan_div_pair
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // clock sources and chip controls
   input  wire logic        internal_oscillator,
   input  wire logic        ext_clock_in,
   input  wire logic [1:0]  clock_input_select,
   input  wire logic        sync_request,
   // output pairs
   output logic             pair_a_output_p,
   output logic             pair_a_output_n,
   output logic             pair_b_output_p,
   output logic             pair_b_output_n,
   // duty correction enables for the output stage
   output logic             pair_a_duty_fix_en,
   output logic             pair_b_duty_fix_en
);

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------

   chan_div_pkg::avl_req_s req;
   logic [47:0]            contents;
   logic [7:0]             rd_byte;
   logic [2:0]             sel;
   logic                   hit;
   logic                   ack;
   logic [9:0]             index;

   assign req   = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};
   assign index = req.address[11:2];

   // map a register index to its slot; slot 7 means unmapped
   function automatic logic [2:0] slot_of(input logic [9:0] idx);
      if (idx == chan_div_pkg::idx_div0_cycle_counts)
         slot_of = 3'd0;
      else if (idx == chan_div_pkg::idx_div0_control)
         slot_of = 3'd1;
      else if (idx == chan_div_pkg::idx_div0_routing)
         slot_of = 3'd2;
      else if (idx == chan_div_pkg::idx_div1_cycle_counts)
         slot_of = 3'd3;
      else if (idx == chan_div_pkg::idx_div1_control)
         slot_of = 3'd4;
      else if (idx == chan_div_pkg::idx_div1_routing)
         slot_of = 3'd5;
      else
         slot_of = 3'd7;
   endfunction

   assign sel = slot_of(index);
   assign hit = (sel != 3'd7);

   // one wait cycle: ack rises the cycle after a request, read data then ready
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         ack <= 1'b0;
      else
         ack <= (req.read || req.write) && !ack;
   end

   assign avs_waitrequest = (req.read || req.write) && !ack;

   chan_div_regfile u_regs
   (
      .clk      (clk),
      .rst_b    (rst_b),
      .wr_en    (req.write && ack && hit && req.byteenable[0]),
      .wr_sel   (sel),
      .wr_data  (req.writedata[7:0]),
      .rd_sel   (sel),
      .rd_hit   (req.read && !ack && hit),
      .rd_data  (rd_byte),
      .contents (contents)
   );

   assign avs_readdata = {24'h00_0000, rd_byte};

   // ------------------------------------------------------------
   // sync request synchroniser
   // ------------------------------------------------------------

   logic sync_m1;
   logic sync_m2;
   logic sync_m3;
   logic sync_level;
   logic sync_level_d;
   logic sync_pulse;

   // three stages; a change counts when the second and third agree
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync_m1    <= 1'b0;
         sync_m2    <= 1'b0;
         sync_m3    <= 1'b0;
         sync_level <= 1'b0;
      end
      else
      begin
         sync_m1 <= sync_request;
         sync_m2 <= sync_m1;
         sync_m3 <= sync_m2;
         if (sync_m2 == sync_m3)
            sync_level <= sync_m3;
      end
   end

   // rising edge of the filtered level restarts both dividers together
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         sync_level_d <= 1'b0;
      else
         sync_level_d <= sync_level;
   end

   assign sync_pulse = sync_level && !sync_level_d;

   // ------------------------------------------------------------
   // dividers and routing
   // ------------------------------------------------------------

   logic [1:0] div_out;
   logic [1:0] pair_level;
   logic       source_clock;

   // oscillator is the default source; external when selected
   assign source_clock = (clock_input_select == chan_div_pkg::sel_ext_clock) ?
                         ext_clock_in : internal_oscillator;

   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : chan
         chan_div_pkg::div_cfg_s cfg;
         logic [7:0]             cyc;
         logic [7:0]             ctl;
         logic [7:0]             rte;

         assign cyc = contents[(c*3+0)*8 +: 8];
         assign ctl = contents[(c*3+1)*8 +: 8];
         assign rte = contents[(c*3+2)*8 +: 8];

         // field unpack
         assign cfg.low_cycles       = cyc[7:4];
         assign cfg.high_cycles      = cyc[3:0];
         assign cfg.bypass           = ctl[chan_div_pkg::bit_bypass];
         assign cfg.sync_ignore      = ctl[chan_div_pkg::bit_sync_ignore];
         assign cfg.force_level      = ctl[chan_div_pkg::bit_force_level];
         assign cfg.start_level      = ctl[chan_div_pkg::bit_start_level];
         assign cfg.phase_offset     = ctl[3:0];
         assign cfg.direct_route     = rte[chan_div_pkg::bit_direct];
         assign cfg.duty_fix_disable = rte[chan_div_pkg::bit_duty_off];

         chan_div_counter u_div
         (
            .clk      (clk),
            .rst_b    (rst_b),
            .cfg      (cfg),
            .sync_req (sync_pulse),
            .div_out  (div_out[c]),
            .running  ()
         );

         // pick the level for this pair: direct, bypass or divided
         always_comb
         begin
            if (cfg.direct_route &&
                clock_input_select == chan_div_pkg::sel_oscillator)
               pair_level[c] = internal_oscillator;
            else if (cfg.direct_route &&
                     clock_input_select == chan_div_pkg::sel_ext_clock)
               pair_level[c] = ext_clock_in;
            else if (cfg.bypass)
               pair_level[c] = source_clock;
            else
               pair_level[c] = div_out[c];
         end
      end
   endgenerate

   // differential pairs; true and complement of the routed level
   assign pair_a_output_p = pair_level[0];
   assign pair_a_output_n = !pair_level[0];
   assign pair_b_output_p = pair_level[1];
   assign pair_b_output_n = !pair_level[1];

   // duty correction is analog; only its enable leaves this block
   assign pair_a_duty_fix_en = !chan[0].cfg.duty_fix_disable;
   assign pair_b_duty_fix_en = !chan[1].cfg.duty_fix_disable;

endmodule

// *** test/chan_div_pair_monitor.sv ***
// port checker of the channel divider pair, bound onto the top module
`timescale 1ns/1ps
module chan_div_pair_monitor
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // register bus
   input wire logic [11:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // sources and outputs
   input wire logic        internal_oscillator,
   input wire logic        ext_clock_in,
   input wire logic [1:0]  clock_input_select,
   input wire logic        pair_a_output_p,
   input wire logic        pair_b_output_p,
   input wire logic        pair_b_output_n,
   input wire logic        pair_a_duty_fix_en,
   input wire logic        pair_b_duty_fix_en
);
   logic [9:0] idx;
   logic       hit;
   logic       ack;
   logic [7:0] shd [6];

   // accepted bus cycles and the mapped window
   assign idx = avs_address[11:2];
   assign hit = idx >= 10'h190 && idx <= 10'h195;
   assign ack = (avs_read || avs_write) && !avs_waitrequest;

   // shadow of the settings, so outputs can be tied to what software wrote
   always_ff @(posedge clk)
      if (!rst_b)
         shd <= '{default: 8'h00};
      else if (ack && avs_write && avs_byteenable[0] && hit)
         shd[3'(idx - 10'h190)] <= avs_writedata[7:0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait");
   a_read_data: assert property (ack && avs_read && hit
      |-> avs_readdata == {24'h00_0000, shd[3'(idx - 10'h190)]}) else $error("bad read");
   a_read_none: assert property (ack && avs_read && !hit
      |-> avs_readdata == 32'h0000_0000) else $error("bad unmapped read");
   a_force_high: assert property ((shd[4][7:5] == 3'b011 && !shd[5][1])[*4]
      |-> pair_b_output_p && !pair_b_output_n) else $error("force high lost");
   a_force_low: assert property ((shd[4][7:5] == 3'b010 && !shd[5][1])[*4]
      |-> !pair_b_output_p && pair_b_output_n) else $error("force low lost");
   a_direct_osc: assert property (shd[2][1] && clock_input_select == 2'h2
      |-> pair_a_output_p == internal_oscillator) else $error("bad direct osc");
   a_direct_ext: assert property (shd[5][1] && clock_input_select == 2'h0
      |-> pair_b_output_p == ext_clock_in) else $error("bad direct ext");
   a_bypass_src: assert property (shd[1][7] && !shd[2][1]
      |-> pair_a_output_p == (clock_input_select == 2'h0 ? ext_clock_in : internal_oscillator))
      else $error("bad bypass");
   a_duty_follow: assert property (pair_a_duty_fix_en == !shd[2][0]
      && pair_b_duty_fix_en == !shd[5][0]) else $error("bad duty enable");

   c_read: cover property (ack && avs_read && hit);
   c_force: cover property (shd[4][6:5] == 2'b11);
   c_direct: cover property (shd[2][1] && clock_input_select == 2'h2);
endmodule

bind chan_div_pair chan_div_pair_monitor mon (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .internal_oscillator,
   .ext_clock_in, .clock_input_select, .pair_a_output_p, .pair_b_output_p, .pair_b_output_n,
   .pair_a_duty_fix_en, .pair_b_duty_fix_en);

// *** test/clock_sink_probe.sv ***
// downstream clock sink model that measures whole runs of a divided clock
`timescale 1ns/1ps
module clock_sink_probe
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // observed clock and last whole runs
   input  wire logic       level,
   output logic      [5:0] last_low,
   output logic      [5:0] last_high
);
   logic [5:0] run;
   logic       prev;

   // run counter restarts on every flip of the observed level
   always_ff @(posedge clk)
      if (!rst_b)
      begin
         run <= 6'h1;
         prev <= 1'b0;
      end
      else
      begin
         run <= (level != prev) ? 6'h1 : run + 6'h1;
         prev <= level;
      end

   // only finished runs are reported, at the flip that ends them; a run cut short by reprogramming is reported too
   always_ff @(posedge clk)
      if (!rst_b)
      begin
         last_low <= 6'h0;
         last_high <= 6'h0;
      end
      else if (level != prev && prev)
         last_high <= run;
      else if (level != prev)
         last_low <= run;
endmodule

// *** test/channel_divider_pair_test.sv ***
// self-checking bench of the channel divider pair
`timescale 1ns/1ps
module channel_divider_pair_test;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        internal_oscillator = 1'b0;
   logic        ext_clock_in = 1'b0;
   logic [1:0]  clock_input_select = 2'h0;
   logic        sync_request = 1'b0;
   logic        pair_a_output_p, pair_a_output_n, pair_b_output_p, pair_b_output_n;
   logic        pair_a_duty_fix_en, pair_b_duty_fix_en;
   logic [5:0]  last_low, last_high;
   logic [7:0]  exp_reg [7] = '{default: 8'h00};
   logic [31:0] exp_q [$];
   logic [2:0]  hist = 3'h0;
   logic [7:0]  v;
   int          errors = 0;
   int          check_count = 0;

   chan_div_pair dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .internal_oscillator, .ext_clock_in,
      .clock_input_select, .sync_request, .pair_a_output_p, .pair_a_output_n,
      .pair_b_output_p, .pair_b_output_n, .pair_a_duty_fix_en, .pair_b_duty_fix_en);
   clock_sink_probe probe (.clk, .rst_b, .level(pair_a_output_p), .last_low, .last_high);

   always #20 clk = ~clk;

   // raw sources are redrawn at random every cycle so routed paths are checked on live data
   always @(posedge clk)
   begin
      internal_oscillator <= 1'($urandom);
      ext_clock_in <= 1'($urandom);
   end

   // read data is matched against the oldest note at the accepting edge
   always @(posedge clk)
      if (avs_read && avs_waitrequest === 1'b0)
         compare_word(avs_readdata, exp_q.pop_front());

   task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic compare_level(input logic got, input logic exp);
      compare_word({31'h0, got}, {31'h0, exp});
   endtask

   // one bus cycle, held until waitrequest is seen low, then one idle cycle
   task automatic bus(input logic wr, input int i, input logic [7:0] d);
      avs_address <= 12'h640 + 12'(4 * i);
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'($urandom), d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   // slot six is unmapped and always reads zero
   task automatic wr(input int i, input logic [7:0] d);
      if (i < 6 && avs_byteenable[0])
         exp_reg[i] = d;
      bus(1'b1, i, d);
   endtask

   task automatic rd(input int i);
      exp_q.push_back({24'h00_0000, exp_reg[i]});
      bus(1'b0, i, 8'h00);
   endtask

   task automatic follow(input logic use_ext, input logic on_b);
      repeat (8)
      begin
         @(negedge clk);
         compare_level(on_b ? pair_b_output_p : pair_a_output_p,
            use_ext ? ext_clock_in : internal_oscillator);
      end
      @(posedge clk);
   endtask

   // held long enough to pass the input filter
   task automatic sync_pulse;
      sync_request <= 1'b1;
      repeat (6) @(posedge clk);
      sync_request <= 1'b0;
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      void'($urandom(32'h0000_192e));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // reset values, random fill, a write with its byte lane off
      for (int i = 0; i < 7; i++)
         rd(i);
      for (int i = 0; i < 7; i++)
         wr(i, 8'($urandom));
      avs_byteenable <= 4'h0;
      @(posedge clk);
      wr(3, 8'h5a);
      avs_byteenable <= 4'hf;
      @(posedge clk);
      for (int i = 0; i < 7; i++)
         rd(i);
      for (int i = 0; i < 6; i++)
         wr(i, 8'h00);
      $display("register test done");
      // longest low run against a single high cycle, then random counts
      for (int k = 0; k < 3; k++)
      begin
         v = (k == 0) ? 8'hf1 : {4'($urandom_range(15, 1)), 4'($urandom_range(15, 1))};
         wr(0, v);
         repeat (70) @(posedge clk);
         compare_word({26'h0, last_low}, {28'h0, v[7:4]});
         compare_word({26'h0, last_high}, {28'h0, v[3:0]});
      end
      $display("run length test done");
      // equal counts, second divider three cycles late after a shared sync
      wr(0, 8'h33);
      wr(3, 8'h33);
      wr(1, 8'h00);
      wr(4, 8'h03);
      sync_pulse;
      repeat (20) @(posedge clk);
      for (int k = 0; k < 27; k++)
      begin
         @(posedge clk);
         if (k > 2)
            compare_level(pair_b_output_p, hist[2]);
         hist = {hist[1:0], pair_a_output_p};
      end
      // opposite start levels seen inside a long offset
      wr(1, 8'h1f);
      wr(4, 8'h0f);
      sync_pulse;
      repeat (6) @(posedge clk);
      @(negedge clk);
      compare_level(pair_a_output_p, 1'b1);
      compare_level(pair_b_output_p, 1'b0);
      @(posedge clk);
      $display("phase test done");
      // forcing only with sync ignored, then routing on the forced pair
      wr(4, 8'h60);
      repeat (4) @(posedge clk);
      @(negedge clk);
      compare_level(pair_b_output_p, 1'b1);
      compare_level(pair_b_output_n, 1'b0);
      @(posedge clk);
      wr(4, 8'h40);
      wr(5, 8'h02);
      clock_input_select <= 2'h1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      compare_level(pair_b_output_p, 1'b0);
      @(posedge clk);
      clock_input_select <= 2'h0;
      follow(1'b1, 1'b1);
      clock_input_select <= 2'h2;
      follow(1'b0, 1'b1);
      wr(5, 8'h00);
      wr(1, 8'h80);
      follow(1'b0, 1'b0);
      clock_input_select <= 2'h0;
      follow(1'b1, 1'b0);
      wr(2, 8'h01);
      @(negedge clk);
      compare_level(pair_a_duty_fix_en, 1'b0);
      compare_level(pair_b_duty_fix_en, 1'b1);
      @(posedge clk);
      $display("routing test done");
      final_report;
   end

   // the whole run needs a few hundred cycles; the limit is 8000
   initial
   begin
      #(40 * 8000);
      errors++;
      final_report;
   end
endmodule
